// >>> sleep_pkg.sv
// Functional notes
// (RULE_01) sleep entry clears watchdog; counts if enabled
// (RULE_02) entry clears power-down flag, sets expiry flag
// (RULE_03) cpu clock gated, slow oscillators keep running
// (RULE_04) io ports hold their pre-sleep drive
// (RULE_05) non-watchdog resets stay effective in sleep
// (RULE_06) wake on resets, watchdog, enabled interrupts
// (RULE_07) reset wakes reset device; others resume
// (RULE_08) wake needs source enable, ignores global enable
// (RULE_09) next instruction prefetched during sleep instruction
// (RULE_10) global enable picks inline or interrupt branch
// (RULE_11) interrupt routine starts at fixed vector
// (RULE_12) every wake clears the watchdog
// (RULE_13) pending interrupt makes sleep a no-op
// (RULE_14) late interrupt: sleep completes, wakes at once
// (RULE_15) crystal modes wait oscillator start-up delay
// (RULE_16) flags set regardless of any enable
// (RULE_17) collision flag bit 1, sticky until cleared
// (RULE_18) completion flag bit 0, sticky until cleared
// (RULE_19) flag register bits 7-6 read zero
// (RULE_20) watchdog resets device on missed clear
// (RULE_21) four watchdog modes: on, not-sleep, soft, off
// (RULE_22) watchdog expiry in sleep wakes, no reset
// (RULE_23) non-crystal clocks resume without start-up delay
package sleep_pkg;
  // register offsets
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_PIE4 = 4'h1;
  localparam logic [3:0] OFF_STAT = 4'h2;
  localparam logic [3:0] OFF_WDTC = 4'h3;
  // field positions
  localparam int BIT_DONE = 0;
  localparam int BIT_COLL = 1;
  localparam int BIT_TO = 4;
  localparam int BIT_PWRDN = 3;
  localparam int BIT_SWEN = 0;
  localparam int PS_LO = 1;
  localparam int PS_HI = 5;
  // watchdog modes
  localparam logic [1:0] WDTE_ON = 2'h3;
  localparam logic [1:0] WDTE_NOSLP = 2'h2;
  localparam logic [1:0] WDTE_SW = 2'h1;
  // period select: 1:32 at code 0, up to code 12h
  localparam logic [4:0] WDTPS_RST = 5'h0b;
  localparam logic [4:0] WDTPS_MAX = 5'h12;
  localparam logic [4:0] WDT_BASE_SH = 5'h05;
  // oscillator modes that use a crystal
  localparam logic [2:0] OSC_XTAL_LOWP = 3'h0;
  localparam logic [2:0] OSC_XTAL_STD = 3'h1;
  localparam logic [2:0] OSC_XTAL_FAST = 3'h2;
  // start-up delay, in oscillator periods
  localparam logic [10:0] OST_LAST = 11'h3ff;
  localparam logic [15:0] ISR_VECTOR = 16'h0004;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST} st_t;

  // register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // interrupt sources other than the second serial port
  typedef struct packed {
    logic ext_flag;
    logic ext_en;
    logic [7:0] per_flag;
    logic [7:0] per_en;
  } irq_in_t;

  // whole state of the controller
  typedef struct packed {
    st_t state;
    logic clrpin_s1, clrpin_s2;
    logic brown_s1, brown_s2;
    logic por_s1, por_s2;
    logic tick_s1, tick_s2, tick_s3;
    logic pwrdn_n, to_n;
    logic [1:0] sp2_flags, pie4;
    logic [4:0] period_sel;
    logic swdten;
    logic [23:0] wdt_cnt;
    logic [10:0] ost_cnt;
    logic by_irq;
    logic [7:0] rdata;
    logic reset_req, wake, isr_call, prefetch;
    logic [15:0] isr_addr;
  } ctl_t;

  // vector output stands at its fixed value from reset on
  localparam ctl_t CTL_RST = '{state: ST_RUN, clrpin_s1: 1'b1,
    clrpin_s2: 1'b1, pwrdn_n: 1'b1, to_n: 1'b1, period_sel: WDTPS_RST,
    isr_addr: ISR_VECTOR, default: '0};
endpackage : sleep_pkg

// >>> sleep_wake_controller.sv
`timescale 1ns/1ns
module sleep_wake_controller
  import sleep_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // core side, same clock
  input wire logic sleep_exec,
  input wire logic watchdog_clear_exec,
  input wire logic global_irq_enable,
  // configuration levels
  input wire logic [1:0] wdt_mode,
  input wire logic [2:0] osc_mode,
  input wire logic master_clear_enable,
  input wire logic brownout_enable,
  // asynchronous pins and analog events
  input wire logic master_clear_pin_n,
  input wire logic brownout_low,
  input wire logic por_event,
  input wire logic low_freq_tick,
  // wake sources
  input wire irq_in_t irq_in,
  input wire logic serial_port2_collision_evt,
  input wire logic serial_port2_done_evt,
  // register port
  input wire bus_req_t bus_req,
  output logic [7:0] rd_data,
  // control outputs
  output logic cpu_clk_en,
  output logic io_hold,
  output logic slow_osc_run,
  output logic device_reset_req,
  output logic wake_resume,
  output logic prefetch_next,
  output logic isr_call,
  output logic [15:0] isr_addr,
  output logic power_down_flag_n,
  output logic watchdog_expiry_flag_n
);

  ctl_t r; // registered state
  ctl_t n; // next state

  // decoded helpers
  logic pin_rst, brown_rst, por_rst, full_rst;
  logic irq_pend, tick_edge, wdt_on, wdt_exp, xtal;
  logic [4:0] sel_eff;
  logic [23:0] wdt_last;
  logic [7:0] rd_val;

  // reset sources, already through two flops each
  assign pin_rst = master_clear_enable && !r.clrpin_s2;
  assign brown_rst = brownout_enable && r.brown_s2;
  assign por_rst = r.por_s2;
  assign full_rst = pin_rst || brown_rst || por_rst; // [RULE_05]

  // any enabled source, global enable deliberately ignored
  assign irq_pend = (irq_in.ext_flag && irq_in.ext_en)
    || |(irq_in.per_flag & irq_in.per_en)
    || |(r.sp2_flags & r.pie4); // [RULE_08]

  // slow tick edge, read only past the second flop
  assign tick_edge = r.tick_s2 && !r.tick_s3;

  // watchdog enable per mode
  always_comb begin
    case (wdt_mode)
      WDTE_ON: wdt_on = 1'b1; // [RULE_21]
      WDTE_NOSLP: wdt_on = (r.state == ST_RUN); // [RULE_21]
      WDTE_SW: wdt_on = r.swdten; // [RULE_21]
      default: wdt_on = 1'b0; // [RULE_21]
    endcase
  end

  // reserved period codes fall back to the shortest
  assign sel_eff = (r.period_sel > WDTPS_MAX) ? '0 : r.period_sel;
  assign wdt_last = (24'h1 << (WDT_BASE_SH + sel_eff)) - 24'h1;
  // the start-up timer holds the count clear as well
  assign wdt_exp = wdt_on && tick_edge && (r.wdt_cnt == wdt_last)
    && (r.state != ST_OST); // [RULE_20]

  // crystal modes need the start-up wait
  assign xtal = (osc_mode == OSC_XTAL_LOWP) || (osc_mode == OSC_XTAL_STD)
    || (osc_mode == OSC_XTAL_FAST); // [RULE_15]

  // register read mux
  always_comb begin
    rd_val = '0;
    if (bus_req.addr == OFF_FLAGS) begin
      rd_val[1:0] = r.sp2_flags; // upper bits stay zero [RULE_19]
    end else if (bus_req.addr == OFF_PIE4) begin
      rd_val[1:0] = r.pie4;
    end else if (bus_req.addr == OFF_STAT) begin
      rd_val[BIT_TO] = r.to_n;
      rd_val[BIT_PWRDN] = r.pwrdn_n;
    end else if (bus_req.addr == OFF_WDTC) begin
      rd_val[PS_HI:PS_LO] = r.period_sel;
      rd_val[BIT_SWEN] = r.swdten;
    end
  end

  // all next-state logic
  always_comb begin
    n = r;
    // synchronisers
    n.clrpin_s1 = master_clear_pin_n;
    n.clrpin_s2 = r.clrpin_s1;
    n.brown_s1 = brownout_low;
    n.brown_s2 = r.brown_s1;
    n.por_s1 = por_event;
    n.por_s2 = r.por_s1;
    n.tick_s1 = low_freq_tick;
    n.tick_s2 = r.tick_s1;
    n.tick_s3 = r.tick_s2;
    // pulses last one cycle
    n.reset_req = 1'b0;
    n.wake = 1'b0;
    n.isr_call = 1'b0;
    n.prefetch = 1'b0;
    // read data stands for one cycle only
    n.rdata = bus_req.rd ? rd_val : '0;
    // register writes
    if (bus_req.wr) begin
      if (bus_req.addr == OFF_FLAGS) begin
        n.sp2_flags = bus_req.wdata[1:0];
      end else if (bus_req.addr == OFF_PIE4) begin
        n.pie4 = bus_req.wdata[1:0];
      end else if (bus_req.addr == OFF_WDTC) begin
        n.period_sel = bus_req.wdata[PS_HI:PS_LO];
        n.swdten = bus_req.wdata[BIT_SWEN];
      end
    end
    // events win over a same-cycle software clear
    if (serial_port2_collision_evt) begin
      n.sp2_flags[BIT_COLL] = 1'b1; // [RULE_16] [RULE_17]
    end
    if (serial_port2_done_evt) begin
      n.sp2_flags[BIT_DONE] = 1'b1; // [RULE_16] [RULE_18]
    end
    // watchdog counting on the slow tick
    if (!wdt_on || watchdog_clear_exec) begin
      n.wdt_cnt = '0;
    end else if (tick_edge) begin
      n.wdt_cnt = wdt_exp ? '0 : r.wdt_cnt + 24'h1;
    end
    // power state machine
    case (r.state)
      ST_RUN: begin
        if (wdt_exp) begin
          // awake expiry resets the device
          n.reset_req = 1'b1; // [RULE_20]
          n.to_n = 1'b0;
          n.pwrdn_n = 1'b1;
        end else if (sleep_exec && irq_pend) begin
          // sleep acts as a no-op, nothing touched [RULE_13]
          n.state = ST_RUN;
        end else if (sleep_exec) begin
          n.state = ST_SLEEP;
          n.pwrdn_n = 1'b0; // [RULE_02] [RULE_14]
          n.to_n = 1'b1; // [RULE_02] [RULE_14]
          n.wdt_cnt = '0; // [RULE_01]
          n.prefetch = 1'b1; // [RULE_09]
        end
      end
      ST_SLEEP: begin
        // an interrupt that landed late wakes at once
        if (irq_pend || wdt_exp) begin // [RULE_06] [RULE_14]
          n.wdt_cnt = '0; // [RULE_12]
          n.by_irq = irq_pend;
          if (wdt_exp) begin
            n.to_n = 1'b0; // no reset in sleep [RULE_22]
          end
          if (xtal) begin
            n.state = ST_OST; // [RULE_15]
            n.ost_cnt = '0;
          end else begin
            n.state = ST_RUN; // [RULE_23]
            n.wake = 1'b1; // [RULE_07]
            n.isr_call = irq_pend && global_irq_enable; // [RULE_10]
          end
        end
      end
      ST_OST: begin
        // count held clear until the oscillator is up
        n.wdt_cnt = '0; // [RULE_12]
        if (r.ost_cnt == OST_LAST) begin
          n.state = ST_RUN;
          n.wake = 1'b1; // [RULE_07] [RULE_15]
          n.isr_call = r.by_irq && global_irq_enable; // [RULE_10]
        end else begin
          n.ost_cnt = r.ost_cnt + 11'h1;
        end
      end
      default: n.state = ST_RUN;
    endcase
    n.isr_addr = ISR_VECTOR; // [RULE_11]
    // full resets win over everything, asleep or not
    if (full_rst) begin // [RULE_05] [RULE_07]
      n.state = ST_RUN;
      n.reset_req = 1'b1;
      n.wake = 1'b0;
      n.isr_call = 1'b0;
      n.prefetch = 1'b0;
      n.wdt_cnt = '0;
      n.ost_cnt = '0;
      n.by_irq = 1'b0;
      n.sp2_flags = '0;
      n.pie4 = '0;
      n.period_sel = WDTPS_RST;
      n.swdten = 1'b0;
      // pin reset leaves the status flags as they were
      if (brown_rst || por_rst) begin
        n.pwrdn_n = 1'b1;
        n.to_n = 1'b1;
      end
    end
  end

  // single state register, frozen while clk_en is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= CTL_RST;
    end else if (clk_en) begin
      r <= n;
    end
  end

  // outputs
  assign cpu_clk_en = (r.state == ST_RUN); // [RULE_03]
  assign io_hold = (r.state != ST_RUN); // [RULE_04]
  // slow oscillators, timer oscillator and adc rc never gated
  assign slow_osc_run = 1'b1; // [RULE_03]
  assign device_reset_req = r.reset_req;
  assign wake_resume = r.wake;
  assign prefetch_next = r.prefetch;
  assign isr_call = r.isr_call;
  assign isr_addr = r.isr_addr;
  assign power_down_flag_n = r.pwrdn_n;
  assign watchdog_expiry_flag_n = r.to_n;
  assign rd_data = r.rdata;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // sleep instruction taken with nothing pending
  sequence sleep_taken;
    clk_en && r.state == ST_RUN && sleep_exec && !irq_pend
      && !wdt_exp && !full_rst;
  endsequence
  // asleep and an enabled interrupt pending
  sequence irq_in_sleep;
    clk_en && r.state == ST_SLEEP && irq_pend && !full_rst;
  endsequence

  sleep_entry_a: assert property (sleep_taken |=> // [RULE_02]
    r.state == ST_SLEEP && !power_down_flag_n
    && watchdog_expiry_flag_n && prefetch_next)
    else $error("sleep entry flags wrong");

  sleep_nop_a: assert property ( // [RULE_13]
    (clk_en && r.state == ST_RUN && sleep_exec && irq_pend
      && !wdt_exp && !full_rst) |=> r.state == ST_RUN
    && $stable(power_down_flag_n) && $stable(watchdog_expiry_flag_n))
    else $error("sleep not a no-op");

  wdt_entry_a: assert property (sleep_taken |=> // [RULE_01]
    r.wdt_cnt == '0)
    else $error("watchdog not cleared on entry");

  clk_gate_a: assert property ( // [RULE_03]
    (r.state != ST_RUN) |-> !cpu_clk_en && io_hold)
    else $error("cpu clock not gated in sleep");

  irq_wake_a: assert property ( // [RULE_08]
    (irq_in_sleep ##0 !xtal) |=> wake_resume && cpu_clk_en
    && (isr_call == $past(global_irq_enable)))
    else $error("interrupt wake wrong");

  ost_wait_a: assert property ( // [RULE_15]
    (irq_in_sleep ##0 xtal) |=> r.state == ST_OST && !wake_resume
    ##1 (!wake_resume) [*8])
    else $error("start-up delay skipped");

  ost_end_a: assert property ( // [RULE_15]
    (clk_en && r.state == ST_OST && r.ost_cnt == OST_LAST
      && !full_rst) |=> wake_resume && r.wdt_cnt == '0)
    else $error("start-up end did not resume");

  wdt_sleep_a: assert property ( // [RULE_22]
    (clk_en && r.state == ST_SLEEP && wdt_exp && !full_rst)
    |=> !device_reset_req && !watchdog_expiry_flag_n
    && r.state != ST_SLEEP)
    else $error("sleep expiry handled wrong");

  wdt_run_a: assert property ( // [RULE_20]
    (clk_en && r.state == ST_RUN && wdt_exp && !full_rst)
    |=> device_reset_req
    && !watchdog_expiry_flag_n)
    else $error("awake expiry did not reset");

  coll_set_a: assert property ( // [RULE_17]
    (clk_en && serial_port2_collision_evt && !full_rst)
    |=> r.sp2_flags[BIT_COLL])
    else $error("collision flag lost");

  done_set_a: assert property ( // [RULE_18]
    (clk_en && serial_port2_done_evt && !full_rst)
    |=> r.sp2_flags[BIT_DONE])
    else $error("completion flag lost");

  flag_read_a: assert property ( // [RULE_19]
    (clk_en && bus_req.rd && bus_req.addr == OFF_FLAGS)
    |=> rd_data[7:2] == '0 && rd_data[1:0] == $past(r.sp2_flags))
    else $error("flag register read wrong");

  vector_a: assert property ( // [RULE_11]
    isr_call |-> isr_addr == ISR_VECTOR && wake_resume)
    else $error("isr vector wrong");

  full_rst_a: assert property ( // [RULE_05]
    (clk_en && full_rst) |=> device_reset_req && cpu_clk_en)
    else $error("reset lost in sleep");

endmodule : sleep_wake_controller

// >>> wake_source_model.sv
`timescale 1ns/1ns
// far side: external interrupt source and second serial port events
module wake_source_model
  import sleep_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raise_ext, // one-cycle request to set the flag
  input wire logic clear_ext, // isr clears the flag
  input wire logic ext_en, // enable level, passed on one cycle later
  input wire logic coll_req,
  input wire logic done_req,
  output irq_in_t irq_in,
  output logic coll_evt,
  output logic done_evt
);
  // flag latches on its event whatever the enable says
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_in <= '0;
      coll_evt <= 1'b0;
      done_evt <= 1'b0;
    end else begin
      if (raise_ext) begin
        irq_in.ext_flag <= 1'b1;
      end else if (clear_ext) begin
        irq_in.ext_flag <= 1'b0;
      end
      irq_in.ext_en <= ext_en;
      // events are one clock long, like a real port
      coll_evt <= coll_req;
      done_evt <= done_req;
    end
  end
endmodule : wake_source_model

// >>> sleep_wake_controller_test.sv
`timescale 1ns/1ns
module sleep_wake_controller_test;
  import sleep_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0; // held low through the first four edges
  logic sleep_exec = 1'b0;
  logic watchdog_clear_exec = 1'b0;
  logic irq_glob = 1'b0;
  logic [1:0] wdt_mode = 2'h0; // off until the watchdog tests
  logic [2:0] osc_mode = 3'h4; // non-crystal clock
  logic clear_pin_n = 1'b1;
  logic tick = 1'b0;
  logic raise_ext = 1'b0;
  logic clear_ext = 1'b0;
  logic ext_en = 1'b0;
  logic coll_req = 1'b0;
  logic done_req = 1'b0;
  bus_req_t bus_req = '0;
  irq_in_t irq_in;
  logic coll_evt, done_evt, cpu_clk_en, io_hold, slow_osc_run;
  logic device_reset_req, wake_resume, prefetch_next, isr_call;
  logic power_down_flag_n, watchdog_expiry_flag_n;
  logic [7:0] rd_data;
  logic [15:0] isr_addr;
  int mismatches = 0;
  int n_tests = 0;
  int n_resets = 0; // cycles with the reset request high so far
  int r; // snapshot of n_resets
  int n; // cycles to wake
  logic isr; // isr_call seen with the wake

  always #50 clk = ~clk;

  // count cycles with the reset request high; a watchdog reset stands one cycle, a held master clear several
  always @(posedge clk) if (device_reset_req === 1'b1) n_resets++;

  wake_source_model u_wake_source_model (.clk(clk), .rst_b(rst_b),
    .raise_ext(raise_ext), .clear_ext(clear_ext), .ext_en(ext_en),
    .coll_req(coll_req), .done_req(done_req), .irq_in(irq_in),
    .coll_evt(coll_evt), .done_evt(done_evt));

  // clk_en and the brown-out and power-on inputs are tied off
  sleep_wake_controller u_sleep_wake_controller (.clk(clk), .rst_b(rst_b),
    .clk_en(1'b1), .sleep_exec(sleep_exec),
    .watchdog_clear_exec(watchdog_clear_exec),
    .global_irq_enable(irq_glob), .wdt_mode(wdt_mode), .osc_mode(osc_mode),
    .master_clear_enable(1'b1), .brownout_enable(1'b1),
    .master_clear_pin_n(clear_pin_n),
    .brownout_low(1'b0), .por_event(1'b0), .low_freq_tick(tick),
    .irq_in(irq_in), .serial_port2_collision_evt(coll_evt),
    .serial_port2_done_evt(done_evt), .bus_req(bus_req),
    .rd_data(rd_data), .cpu_clk_en(cpu_clk_en), .io_hold(io_hold),
    .slow_osc_run(slow_osc_run), .device_reset_req(device_reset_req),
    .wake_resume(wake_resume), .prefetch_next(prefetch_next),
    .isr_call(isr_call), .isr_addr(isr_addr),
    .power_down_flag_n(power_down_flag_n),
    .watchdog_expiry_flag_n(watchdog_expiry_flag_n));

  task automatic give_verdict;
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // k edges, then let the updates of the last one land
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk) bus_req <= '0;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk) bus_req <= '0;
    #1 chk(rd_data, exp);
  endtask : bus_rd

  task automatic do_sleep;
    @(posedge clk) sleep_exec <= 1'b1;
    @(posedge clk) sleep_exec <= 1'b0;
    #1;
  endtask : do_sleep

  // one-cycle pulse on a source request
  task automatic sp_evt(input logic [2:0] m);
    @(posedge clk) {raise_ext, coll_req, done_req} <= m;
    @(posedge clk) {raise_ext, coll_req, done_req} <= 3'h0;
  endtask : sp_evt

  // slow ticks, three clocks high and four low
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk) tick <= 1'b1;
      repeat (3) @(posedge clk);
      tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : ticks

  // bounded wait for the resume pulse
  task automatic wait_wake(output int cnt, output logic isr_seen);
    cnt = 0;
    isr_seen = 1'bx;
    while (cnt < 1100) begin
      @(posedge clk);
      #1;
      cnt++;
      if (wake_resume === 1'b1) begin
        isr_seen = isr_call;
        return;
      end
    end
    mismatches++;
    give_verdict();
  endtask : wait_wake

  initial begin
    step(4);
    rst_b <= 1'b1;
    step(1);
    // reset values, unmapped address reads zero
    chk({cpu_clk_en, io_hold, power_down_flag_n, watchdog_expiry_flag_n}, 4'hb);
    bus_rd(OFF_STAT, 8'h18);
    bus_rd(OFF_WDTC, 8'h16);
    bus_rd(4'hf, 8'h00);
    // events set flags with every enable clear; flags stick
    sp_evt(3'h2);
    bus_rd(OFF_FLAGS, 8'h02);
    sp_evt(3'h1);
    bus_rd(OFF_FLAGS, 8'h03);
    bus_wr(OFF_FLAGS, 8'hfc);
    bus_rd(OFF_FLAGS, 8'h00);
    // enabled interrupt already pending: sleep does nothing
    ext_en <= 1'b1;
    sp_evt(3'h4);
    step(2);
    do_sleep();
    chk({cpu_clk_en, power_down_flag_n}, 2'h3);
    sp_evt(3'h0);
    @(posedge clk) clear_ext <= 1'b1;
    @(posedge clk) {clear_ext, ext_en} <= 2'h0;
    // sleep entry, disabled source must not wake
    do_sleep();
    chk({cpu_clk_en, io_hold, slow_osc_run}, 3'h3);
    chk(prefetch_next, 1'b1);
    chk({power_down_flag_n, watchdog_expiry_flag_n}, 2'h1);
    sp_evt(3'h4);
    step(20);
    chk(cpu_clk_en, 1'b0);
    @(posedge clk) ext_en <= 1'b1;
    wait_wake(n, isr);
    chk(n <= 3, 1'b1);
    chk({isr, cpu_clk_en}, 2'h1);
    bus_rd(OFF_STAT, 8'h10);
    @(posedge clk) clear_ext <= 1'b1;
    @(posedge clk) {clear_ext, ext_en, irq_glob} <= 3'h1;
    // crystal clock, collision source enabled, global enable set
    osc_mode <= OSC_XTAL_STD;
    bus_wr(OFF_PIE4, 8'h02);
    do_sleep();
    sp_evt(3'h2);
    wait_wake(n, isr);
    chk(n >= 1024 && n <= 1030, 1'b1);
    chk(isr, 1'b1);
    chk(isr_addr, 16'h0004);
    bus_wr(OFF_FLAGS, 8'h00);
    bus_wr(OFF_PIE4, 8'h00);
    osc_mode <= 3'h4;
    // watchdog expiry while asleep wakes without reset
    bus_wr(OFF_WDTC, 8'h00);
    wdt_mode <= WDTE_ON;
    r = n_resets;
    do_sleep();
    ticks(31);
    chk(cpu_clk_en, 1'b0);
    @(posedge clk) tick <= 1'b1;
    wait_wake(n, isr);
    chk(n_resets == r, 1'b1);
    chk({power_down_flag_n, watchdog_expiry_flag_n}, 2'h0);
    @(posedge clk) tick <= 1'b0;
    step(3);
    // awake: the wake cleared it, a clear instruction restarts it
    ticks(31);
    chk(n_resets == r, 1'b1);
    @(posedge clk) watchdog_clear_exec <= 1'b1;
    @(posedge clk) watchdog_clear_exec <= 1'b0;
    ticks(31);
    chk(n_resets == r, 1'b1);
    ticks(1);
    step(4);
    chk(n_resets == r + 1, 1'b1);
    chk(watchdog_expiry_flag_n, 1'b0);
    // off-in-sleep mode leaves the sleeper alone
    wdt_mode <= WDTE_NOSLP;
    do_sleep();
    ticks(40);
    chk(cpu_clk_en, 1'b0);
    // master clear still resets a sleeping device
    @(posedge clk) clear_pin_n <= 1'b0;
    step(6);
    chk(n_resets > r + 1, 1'b1);
    clear_pin_n <= 1'b1;
    step(6);
    give_verdict();
  end
endmodule : sleep_wake_controller_test
